// >>> hdl/tic_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each external input has select bit: 0 senses level, 1 senses edge.
// - External request flag clears on service in edge mode; software writes it only in edge mode.
// - Timer overflow flag clears by hardware when its interrupt is serviced.
// - Timer overflow flag sets when its counter carries out.
// - With qualify bit set, timer 1 counts only while run bit and pin are 1.
module tic_top #(
  parameter int COUNT_WIDTH = tic_pkg::COUNT_WIDTH
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             extint0_pin_n_i,
  input  wire logic             extint1_pin_n_i,
  input  wire tic_pkg::tic_ack_s ack_i,
  output logic      [3:0]       irq_req_o,
  output logic      [7:0]       timer_irq_control_reg_o
);

  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [1:0] pin_d_r;
  logic       pready_r;

  // External pins are active low; a low level or a falling edge requests.
  wire logic ext0_low_w = ~extint0_pin_n_i;
  wire logic ext1_low_w = ~extint1_pin_n_i;
  wire logic ext0_fall_w = pin_d_r[0] & ~extint0_pin_n_i;
  wire logic ext1_fall_w = pin_d_r[1] & ~extint1_pin_n_i;

  wire logic sel0_w  = ctrl_r[tic_pkg::EXT0_SEL_BIT];
  wire logic sel1_w  = ctrl_r[tic_pkg::EXT1_SEL_BIT];
  wire logic run0b_w = ctrl_r[tic_pkg::TMR0_RUN_BIT];
  wire logic run1b_w = ctrl_r[tic_pkg::TMR1_RUN_BIT];
  wire logic qual_w  = mode_r[tic_pkg::MODE_QUAL_BIT];

  // APB decode: the access phase answers after one wait state, since pready is registered.
  // A write lands only at the edge where the master samples pready high, so a write
  // and the answer that confirms it always belong to the same clock edge.
  wire logic acc_w   = psel & penable & ~pready_r;
  wire logic done_w  = psel & penable & pready_r;
  wire logic wr_w    = done_w & pwrite;
  wire logic hit_ctl = paddr == tic_pkg::CTRL_OFFSET;
  wire logic hit_md  = paddr == tic_pkg::MODE_OFFSET;
  wire logic hit_c0  = paddr == tic_pkg::COUNT0_OFFSET;
  wire logic hit_c1  = paddr == tic_pkg::COUNT1_OFFSET;
  wire logic mapped_w = hit_ctl | hit_md | hit_c0 | hit_c1;
  wire logic wr_ctl_w = wr_w & hit_ctl;
  wire logic [7:0] wd_w = pwdata[7:0];

  wire logic run0_w = run0b_w;
  wire logic run1_w = run1b_w & (~qual_w | extint1_pin_n_i);

  logic [COUNT_WIDTH-1:0] cnt0_w;
  logic [COUNT_WIDTH-1:0] cnt1_w;
  logic                   carry0_w;
  logic                   carry1_w;

  tic_counter #(.WIDTH(COUNT_WIDTH)) u_cnt0 (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .run_i      (run0_w),
    .load_i     (wr_w & hit_c0),
    .load_val_i (pwdata[COUNT_WIDTH-1:0]),
    .count_o    (cnt0_w),
    .carry_o    (carry0_w)
  );

  tic_counter #(.WIDTH(COUNT_WIDTH)) u_cnt1 (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .run_i      (run1_w),
    .load_i     (wr_w & hit_c1),
    .load_val_i (pwdata[COUNT_WIDTH-1:0]),
    .count_o    (cnt1_w),
    .carry_o    (carry1_w)
  );

  // Hardware set wins over service clear and over a software clear.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr, input logic sw_wr,
                                     input logic sw_val);
    logic v;
    v = cur;
    if (sw_wr) begin
      v = sw_val;
    end
    if (clr) begin
      v = 1'b0;
    end
    if (set) begin
      v = 1'b1;
    end
    return v;
  endfunction

  // In level mode the flag follows the pin; software cannot touch it.
  wire logic req0_set_w = sel0_w ? ext0_fall_w : ext0_low_w;
  wire logic req1_set_w = sel1_w ? ext1_fall_w : ext1_low_w;
  wire logic req0_clr_w = ack_i.ext0 | (~sel0_w & ~ext0_low_w);
  wire logic req1_clr_w = ack_i.ext1 | (~sel1_w & ~ext1_low_w);

  // The write lock uses the select bit as it stood before the write, so one write
  // that switches to edge mode cannot also set the request flag.
  wire logic req0_nxt = flag_next(ctrl_r[tic_pkg::EXT0_REQ_BIT], req0_set_w, req0_clr_w,
                                  wr_ctl_w & sel0_w, wd_w[tic_pkg::EXT0_REQ_BIT]);
  wire logic req1_nxt = flag_next(ctrl_r[tic_pkg::EXT1_REQ_BIT], req1_set_w, req1_clr_w,
                                  wr_ctl_w & sel1_w, wd_w[tic_pkg::EXT1_REQ_BIT]);
  wire logic ovf0_nxt = flag_next(ctrl_r[tic_pkg::TMR0_OVF_BIT], carry0_w, ack_i.timer0,
                                  wr_ctl_w, wd_w[tic_pkg::TMR0_OVF_BIT]);
  wire logic ovf1_nxt = flag_next(ctrl_r[tic_pkg::TMR1_OVF_BIT], carry1_w, ack_i.timer1,
                                  wr_ctl_w, wd_w[tic_pkg::TMR1_OVF_BIT]);

  wire logic run0_nxt = wr_ctl_w ? wd_w[tic_pkg::TMR0_RUN_BIT] : run0b_w;
  wire logic run1_nxt = wr_ctl_w ? wd_w[tic_pkg::TMR1_RUN_BIT] : run1b_w;
  wire logic sel0_nxt = wr_ctl_w ? wd_w[tic_pkg::EXT0_SEL_BIT] : sel0_w;
  wire logic sel1_nxt = wr_ctl_w ? wd_w[tic_pkg::EXT1_SEL_BIT] : sel1_w;

  wire logic [7:0] ctrl_nxt = {ovf1_nxt, run1_nxt, ovf0_nxt, run0_nxt,
                               req1_nxt, sel1_nxt, req0_nxt, sel0_nxt};
  wire logic [7:0] mode_nxt = (wr_w & hit_md) ? wd_w : mode_r;

  wire logic [31:0] rd_w =
      hit_ctl ? {24'h000000, ctrl_r} :
      hit_md  ? {24'h000000, mode_r} :
      hit_c0  ? {{(32-COUNT_WIDTH){1'b0}}, cnt0_w} :
      hit_c1  ? {{(32-COUNT_WIDTH){1'b0}}, cnt1_w} : 32'h00000000;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r   <= tic_pkg::CTRL_RESET;
      mode_r   <= tic_pkg::MODE_RESET;
      pin_d_r  <= 2'h3;
      pready_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      mode_r   <= mode_nxt;
      pin_d_r  <= {extint1_pin_n_i, extint0_pin_n_i};
      pready_r <= acc_w;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (acc_w & ~pwrite) ? rd_w : 32'h00000000;
      pslverr <= acc_w & ~mapped_w;
    end
  end

  assign pready = pready_r;
  assign timer_irq_control_reg_o = ctrl_r;
  assign irq_req_o = {ctrl_r[tic_pkg::TMR1_OVF_BIT], ctrl_r[tic_pkg::EXT1_REQ_BIT],
                      ctrl_r[tic_pkg::TMR0_OVF_BIT], ctrl_r[tic_pkg::EXT0_REQ_BIT]};

  sequence s_carry1;
    carry1_w;
  endsequence

  // A pin edge is an event only in edge mode; level mode ignores it.
  sequence s_fall0;
    sel0_w && $fell(extint0_pin_n_i);
  endsequence

  sequence s_fall1;
    sel1_w && $fell(extint1_pin_n_i);
  endsequence

  a_ovf1_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_carry1 |=> ctrl_r[tic_pkg::TMR1_OVF_BIT])
    else $error("timer 1 overflow flag not set on carry");
  a_ovf0_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    carry0_w |=> ctrl_r[tic_pkg::TMR0_OVF_BIT])
    else $error("timer 0 overflow flag not set on carry");
  a_ovf0_ack_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ack_i.timer0 && !carry0_w |=> !ctrl_r[tic_pkg::TMR0_OVF_BIT])
    else $error("timer 0 overflow flag not cleared");
  a_ovf1_ack_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ack_i.timer1 && !carry1_w |=> !ctrl_r[tic_pkg::TMR1_OVF_BIT])
    else $error("timer 1 overflow flag not cleared");
  a_ext0_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_fall0 |=> ctrl_r[tic_pkg::EXT0_REQ_BIT])
    else $error("input 0 edge lost");
  a_ext1_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_fall1 |=> ctrl_r[tic_pkg::EXT1_REQ_BIT])
    else $error("input 1 edge lost");
  a_ext1_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sel1_w && !extint1_pin_n_i |=> ctrl_r[tic_pkg::EXT1_REQ_BIT])
    else $error("input 1 level lost");
  a_ext0_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sel0_w && !extint0_pin_n_i |=> ctrl_r[tic_pkg::EXT0_REQ_BIT])
    else $error("input 0 level lost");
  a_ext0_swlock: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sel0_w && wr_ctl_w && extint0_pin_n_i |=> !ctrl_r[tic_pkg::EXT0_REQ_BIT])
    else $error("input 0 flag written in level mode");
  // Service clears an edge request unless a new edge arrives in the same cycle.
  a_ext0_svc_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ack_i.ext0 && sel0_w && !$fell(extint0_pin_n_i) |=> !ctrl_r[tic_pkg::EXT0_REQ_BIT])
    else $error("input 0 flag not cleared by service");
  a_ext1_svc_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ack_i.ext1 && sel1_w && !$fell(extint1_pin_n_i) |=> !ctrl_r[tic_pkg::EXT1_REQ_BIT])
    else $error("input 1 flag not cleared by service");
  a_ext1_swset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sel1_w && wr_ctl_w && wd_w[tic_pkg::EXT1_REQ_BIT] && !ack_i.ext1
    |=> ctrl_r[tic_pkg::EXT1_REQ_BIT])
    else $error("input 1 flag not set by software in edge mode");
  a_cnt0_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !run0b_w && !(wr_w && hit_c0) |=> $stable(cnt0_w))
    else $error("timer 0 moved while stopped");
  // The sum is kept at counter width so the wrap from all ones to zero is legal.
  a_cnt0_runs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    run0b_w && !(wr_w && hit_c0) |=> cnt0_w == ($past(cnt0_w) + 1'b1))
    else $error("timer 0 did not count while running");
  a_cnt1_runs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !qual_w && run1b_w && !(wr_w && hit_c1) |=> cnt1_w == ($past(cnt1_w) + 1'b1))
    else $error("timer 1 did not count on its run bit alone");
  a_cnt1_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    qual_w && !extint1_pin_n_i && !(wr_w && hit_c1) |=> $stable(cnt1_w))
    else $error("timer 1 counted with pin low");

endmodule : tic_top

`default_nettype wire

// >>> hdl/tic_pkg.sv
package tic_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] CTRL_OFFSET     = 8'h88;
  localparam logic [7:0] MODE_OFFSET     = 8'h89;
  localparam logic [7:0] COUNT0_OFFSET   = 8'h8C;
  localparam logic [7:0] COUNT1_OFFSET   = 8'h90;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;

  // Field positions in the control register; MODE_QUAL_BIT is a position in the mode register.
  localparam int EXT0_SEL_BIT = 0;
  localparam int EXT0_REQ_BIT = 1;
  localparam int EXT1_SEL_BIT = 2;
  localparam int EXT1_REQ_BIT = 3;
  localparam int TMR0_RUN_BIT = 4;
  localparam int TMR0_OVF_BIT = 5;
  localparam int TMR1_RUN_BIT = 6;
  localparam int TMR1_OVF_BIT = 7;
  localparam int MODE_QUAL_BIT = 7;

  localparam int COUNT_WIDTH = 16;

  // Service acknowledge strobes from the CPU vectoring logic.
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic ext1;
    logic ext0;
  } tic_ack_s;

endpackage : tic_pkg

// >>> hdl/tic_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Loadable up counter that counts while run_i is high, with a one-cycle carry pulse on wrap.
module tic_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_val_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  carry_o
);

  wire logic             wrap_w = run_i & (&count_o);
  wire logic [WIDTH-1:0] inc_w  = count_o + {{(WIDTH-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
      carry_o <= 1'b0;
    end else begin
      carry_o <= wrap_w & ~load_i;
      if (load_i) begin
        count_o <= load_val_i;
      end else if (run_i) begin
        count_o <= inc_w;
      end
    end
  end

endmodule : tic_counter

`default_nettype wire

// >>> sim/tic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module tic_cpu_model (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic [3:0]        irq_req_i,
  input  wire logic [3:0]        svc_en_i,
  output var  tic_pkg::tic_ack_s ack_o
);
  logic [3:0] ack_r;

  // One service pulse per pending request; the pulse drops so a new request is seen fresh.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 4'h0;
    end else begin
      ack_r <= irq_req_i & svc_en_i & ~ack_r;
    end
  end

  assign ack_o = tic_pkg::tic_ack_s'({ack_r[3], ack_r[1], ack_r[2], ack_r[0]});
endmodule // tic_cpu_model

`default_nettype wire

// >>> sim/tic_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end

module tic_top_test;
  localparam logic [7:0] CTRL = tic_pkg::CTRL_OFFSET;
  localparam logic [7:0] MODE = tic_pkg::MODE_OFFSET;
  localparam logic [7:0] CNT0 = tic_pkg::COUNT0_OFFSET;
  logic              clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, e;
  logic              pin0_n, pin1_n;
  logic [7:0]        paddr, ctrl_img;
  logic [31:0]       pwdata, prdata, v, w;
  logic [3:0]        irq_req, svc_en;
  tic_pkg::tic_ack_s ack;
  int                checks, miscompares;

  tic_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extint0_pin_n_i(pin0_n), .extint1_pin_n_i(pin1_n), .ack_i(ack),
    .irq_req_o(irq_req), .timer_irq_control_reg_o(ctrl_img));
  tic_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .irq_req_i(irq_req),
    .svc_en_i(svc_en), .ack_o(ack));

  task automatic test_done();
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    psel <= 1'b1; pwrite <= wr_en; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 16) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        r;
    apb(1'b1, a, d, q, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        r;
    apb(1'b0, a, 32'h0, q, r);
    `CHK(q, exp)
  endtask

  task automatic pin(input int i, input logic val);
    if (i == 0) pin0_n <= val;
    else pin1_n <= val;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pin0_n = 1'b1; pin1_n = 1'b1; svc_en = 4'h0;
    checks = 0; miscompares = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(CTRL, 32'h0);
    rd(MODE, 32'h0);
    apb(1'b0, 8'h84, 32'h0, v, e);
    `CHK(e, 1'b1)
    for (int i = 0; i < 2; i++) begin
      // Level sensing: the flag follows the pin and software cannot write it.
      wr(CTRL, 32'h1 << (2 * i + 1));
      rd(CTRL, 32'h0);
      pin(i, 1'b0);
      repeat (3) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i], 1'b1)
      pin(i, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i], 1'b0)
      // Edge mode must already stand before software may set the flag.
      wr(CTRL, 32'h1 << (2 * i));
      wr(CTRL, 32'h3 << (2 * i));
      rd(CTRL, 32'h3 << (2 * i));
      `CHK(ctrl_img, 8'h3 << (2 * i))
      wr(CTRL, 32'h1 << (2 * i));
      rd(CTRL, 32'h1 << (2 * i));
      pin(i, 1'b0);
      repeat (3) @(posedge clk_sys_i);
      pin(i, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i], 1'b1)
      svc_en[2 * i] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i], 1'b0)
      svc_en <= 4'h0;
      // Timer near wrap, then serviced, then stopped.
      wr(CTRL, 32'h0);
      wr(CNT0 + 8'(4 * i), 32'h0000FFFE);
      wr(CTRL, 32'h1 << (4 + 2 * i));
      repeat (4) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i + 1], 1'b1)
      svc_en[2 * i + 1] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      `CHK(irq_req[2 * i + 1], 1'b0)
      svc_en <= 4'h0;
      wr(CTRL, 32'h0);
      apb(1'b0, CNT0 + 8'(4 * i), 32'h0, v, e);
      apb(1'b0, CNT0 + 8'(4 * i), 32'h0, w, e);
      `CHK(w, v)
    end
    // Qualified timer 1 waits for its pin.
    wr(MODE, 32'h80);
    wr(CNT0 + 8'h04, 32'h0);
    pin(1, 1'b0);
    wr(CTRL, 32'h40);
    rd(CNT0 + 8'h04, 32'h0);
    pin(1, 1'b1);
    repeat (4) @(posedge clk_sys_i);
    apb(1'b0, CNT0 + 8'h04, 32'h0, v, e);
    `CHK(v != 32'h0, 1'b1)
    test_done();
  end
endmodule // tic_top_test

`default_nettype wire
